// ---- sltx_pkg.sv ----
package sltx_pkg;
    // silo geometry
    localparam int SILO_DEPTH = 64;
    localparam int CHAR_W = 8;
    localparam int ENT_W = 10;
    // entry layout: {eom, som, char}
    localparam int ENT_SOM = 8;
    localparam int ENT_EOM = 9;
    // register indices on register_select
    localparam logic [3:0] REG_TX_DATA = 4'h0;
    localparam logic [3:0] REG_TX_CTRL = 4'h1;
    localparam logic [3:0] REG_MODE = 4'h2;
    localparam logic [3:0] REG_MODEM = 4'h3;
    localparam logic [3:0] REG_SILO = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h5;
    localparam logic [3:0] REG_CRC_LO = 4'h6;
    localparam logic [3:0] REG_CRC_HI = 4'h7;
    // control register bits
    localparam int CTRL_SOM = 0;
    localparam int CTRL_EOM = 1;
    localparam int CTRL_ABORT = 2;
    localparam logic [1:0] CTRL_RST = 2'h0;
    // mode register bits
    localparam int MODE_STUFF = 0;
    localparam int MODE_INV = 1;
    localparam int MODE_DTR = 2;
    localparam int MODE_MAINT = 3;
    localparam int MODE_MCLK = 4;
    localparam logic [4:0] MODE_RST = 5'h00;
    // line characters
    localparam logic [7:0] FLAG_CHAR = 8'h7E;
    localparam logic [7:0] PAD_CHAR = 8'hFF;
    localparam logic [7:0] ABORT_CHAR = 8'hFF;
    // block check
    localparam logic [15:0] CRC16_POLY = 16'hA001;
    localparam logic [15:0] CCITT_POLY = 16'h8408;
    localparam logic [15:0] CRC_PRESET = 16'h0000;
    // bit engine
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // transmitter states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_OPEN = 3'b011,
        ST_RUN = 3'b010,
        ST_CRC_LO = 3'b110,
        ST_CRC_HI = 3'b111,
        ST_CLOSE = 3'b101,
        ST_ABORT = 3'b100
    } sltx_state_t;
    // one reflected crc step, lsb first
    function automatic logic [15:0] sltx_crc_step(input logic [15:0] crc, input logic b, input logic [15:0] poly);
        logic fb;
        fb = crc[0] ^ b;
        return (crc >> 1) ^ (fb ? poly : 16'h0000);
    endfunction
endpackage

// ---- sltx_mem.sv ----
// small silo store, registered read port
module sltx_mem #(
    parameter int W = 10,
    parameter int D = 64
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [$clog2(D)-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [$clog2(D)-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    // storage array, no reset needed
    logic [W-1:0] mem_q [D];

    // write port
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // read port, registered every cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule // sltx_mem

// ---- sltx_top.sv ----
// Operation
// R1: serialise each character lsb first
// R2: byte mode uses 8-bit chars, crc-16
// R3: bit-stuff mode uses flags and ccitt crc
// R4: zero insertion, flags and aborts sent automatically
// R5: pad characters sent without host supply
// R6: eight-bit write bus, select, write strobe
// R7: reads only on host request, separate bus
// R8: 64-entry write-only silo drained by transmitter
// R9: som and eom travel with each char
// R10: host sets som then writes data
// R11: som at silo output raises rts; code raises it for any character at the silo output
// R12: modem answers with cts and dsr
// R13: send only when cts and dsr true; code checks them only when loading the first lead-in byte
// R14: som characters kept out of crc
// R15: later characters folded into crc
// R16: block check sent after eom character
// R17: fresh crc for data after eom
// R18: drive dtr and rts, watch dsr cts ring
// R19: maintenance mode alters transmitter operation
// R20: block check uninverted unless option set
// R21: crc preset zero, sent lsb first
// R22: writes to full silo are dropped
module sltx_top import sltx_pkg::*; #(
    parameter int DEPTH = SILO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] register_select,
    input wire logic [7:0] host_write_bus,
    input wire logic host_write_strobe,
    input wire logic host_read_strobe,
    output logic [7:0] read_return_bus,
    input wire logic tx_clk_in,
    output logic tx_data_out,
    output logic rts_out,
    output logic dtr_out,
    input wire logic cts_in,
    input wire logic dsr_in,
    input wire logic ring_in
);
    localparam int AW = $clog2(DEPTH);

    // two-stage synchronisers for clock and modem lines
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    // previous bit clock level
    logic bclk_prev_q;
    // host-side registers
    logic [1:0] ctrl_q;
    logic [4:0] mode_q;
    logic abort_req_q;
    // silo pointers and fill
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic head_ok_q;
    logic [ENT_W-1:0] head;
    // transmitter state
    sltx_state_t state_q;
    sltx_state_t st_d;
    logic [7:0] sh_q;
    logic [2:0] bit_cnt_q;
    logic [2:0] ones_q;
    logic crc_en_q;
    logic stuff_q;
    logic [15:0] crc_q;
    logic eom_pend_q;
    logic eom_d;
    logic msg_q;
    logic msg_d;
    // next-byte choice
    logic [7:0] nb;
    logic ncrc;
    logic nstuff;
    logic pop;
    logic load;
    // derived strobes
    logic ring_s;
    logic cts_s;
    logic dsr_s;
    logic bclk;
    logic tick;
    logic ready;
    logic streaming;
    logic stuff_now;
    logic byte_done;
    logic full;
    logic push;
    logic stuff_mode;
    logic [15:0] poly;
    // accumulator including a bit folded in this very cycle
    logic [15:0] crc_now;
    logic [15:0] crc_out;

    // line inputs pass two flops first
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {tx_clk_in, cts_in, dsr_in, ring_in};
            sync2_q <= sync1_q;
        end
    end

    assign ring_s = sync2_q[0];
    assign dsr_s = sync2_q[1];
    assign cts_s = sync2_q[2];
    assign stuff_mode = mode_q[MODE_STUFF];

    // maintenance: software clock, modem forced ready
    // R19 maintenance overrides
    assign bclk = mode_q[MODE_MAINT] ? mode_q[MODE_MCLK] : sync2_q[3];
    // R13 modem handshake gate
    assign ready = mode_q[MODE_MAINT] | (cts_s & dsr_s);

    // falling bit clock edge launches a bit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bclk_prev_q <= 1'b0;
        end else begin
            bclk_prev_q <= bclk;
        end
    end

    assign tick = bclk_prev_q & ~bclk;
    assign streaming = (state_q != ST_IDLE) && (state_q != ST_WAIT);
    // R4 run of five ones forces a zero
    assign stuff_now = (ones_q == STUFF_RUN);
    assign byte_done = tick && streaming && !stuff_now && (bit_cnt_q == LAST_BIT);
    assign load = ((state_q == ST_WAIT) && ready) || byte_done;
    // R2 R3 polynomial by mode
    assign poly = stuff_mode ? CCITT_POLY : CRC16_POLY;
    // last data bit folds at the boundary that loads the low check byte
    assign crc_now = (tick && !stuff_now && crc_en_q) ? sltx_crc_step(crc_q, sh_q[0], poly) : crc_q;
    // R20 optional inversion at the output
    assign crc_out = mode_q[MODE_INV] ? ~crc_now : crc_now;

    // control register: som/eom for next entries
    // R10 host sets som before data
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= CTRL_RST;
        end else if (host_write_strobe && register_select == REG_TX_CTRL) begin
            ctrl_q <= host_write_bus[1:0];
        end
    end

    // abort request: write sets, launch clears, set wins
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            abort_req_q <= 1'b0;
        end else if (host_write_strobe && register_select == REG_TX_CTRL && host_write_bus[CTRL_ABORT]) begin
            abort_req_q <= 1'b1;
        end else if ((load && streaming) || state_q == ST_IDLE) begin
            abort_req_q <= 1'b0;
        end
    end

    // mode register
    // R6 register write path
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_q <= MODE_RST;
        end else if (host_write_strobe && register_select == REG_MODE) begin
            mode_q <= host_write_bus[4:0];
        end
    end

    // R18 terminal ready from software
    assign dtr_out = mode_q[MODE_DTR];

    // silo write side
    assign full = (cnt_q == (AW+1)'(DEPTH));
    // R22 writes dropped when full
    assign push = host_write_strobe && (register_select == REG_TX_DATA) && !full;

    // R8 silo pointers and fill count
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // head valid in the same cycle as the registered read data settles
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            head_ok_q <= 1'b0;
        end else begin
            head_ok_q <= (cnt_q != '0) && !pop;
        end
    end

    // R9 control bits stored beside each char
    sltx_mem #(
        .W(ENT_W),
        .D(DEPTH)
    ) u_silo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr_en(push),
        .wr_addr(wp_q),
        .wr_data({ctrl_q[CTRL_EOM], ctrl_q[CTRL_SOM], host_write_bus}),
        .rd_addr(rp_q),
        .rd_data(head)
    );

    // next state and next byte at each byte boundary
    always_comb begin
        st_d = state_q;
        nb = PAD_CHAR;
        ncrc = 1'b0;
        nstuff = 1'b0;
        pop = 1'b0;
        eom_d = eom_pend_q;
        msg_d = msg_q;
        if (load && streaming && abort_req_q) begin
            // R4 abort sent unstuffed
            st_d = ST_ABORT;
            nb = ABORT_CHAR;
        end else if (load) begin
            case (state_q)
                ST_WAIT: begin
                    // R5 lead-in fill
                    st_d = ST_OPEN;
                    nb = stuff_mode ? FLAG_CHAR : PAD_CHAR;
                end
                ST_CRC_LO: begin
                    // R21 high byte follows low byte
                    st_d = ST_CRC_HI;
                    nb = crc_out[15:8];
                    nstuff = stuff_mode;
                end
                ST_OPEN, ST_RUN, ST_CRC_HI: begin
                    if (eom_pend_q && state_q != ST_CRC_HI) begin
                        // R16 check follows eom char
                        st_d = ST_CRC_LO;
                        nb = crc_out[7:0];
                        nstuff = stuff_mode;
                        eom_d = 1'b0;
                        msg_d = 1'b0;
                    end else if (head_ok_q) begin
                        // R14 R15 som decides crc use
                        st_d = ST_RUN;
                        nb = head[7:0];
                        ncrc = !head[ENT_SOM];
                        nstuff = stuff_mode;
                        pop = 1'b1;
                        eom_d = head[ENT_EOM];
                        msg_d = !head[ENT_EOM];
                    end else if (msg_q) begin
                        // R5 fill while message open
                        st_d = ST_RUN;
                        nb = stuff_mode ? FLAG_CHAR : PAD_CHAR;
                    end else begin
                        // closing flag or pad
                        st_d = ST_CLOSE;
                        nb = stuff_mode ? FLAG_CHAR : PAD_CHAR;
                    end
                end
                default: begin
                    // close or abort done
                    st_d = ST_IDLE;
                    eom_d = 1'b0;
                    msg_d = 1'b0;
                end
            endcase
        end else if (state_q == ST_IDLE && head_ok_q) begin
            // R11 data at silo output wakes the line
            st_d = ST_WAIT;
        end
    end

    // state, message and eom tracking
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            eom_pend_q <= 1'b0;
            msg_q <= 1'b0;
        end else begin
            state_q <= st_d;
            eom_pend_q <= eom_d;
            msg_q <= msg_d;
        end
    end

    // R18 request to send registered
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rts_out <= 1'b0;
        end else begin
            rts_out <= (st_d != ST_IDLE);
        end
    end

    // shifter: load at boundary, shift on each real bit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sh_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            crc_en_q <= 1'b0;
            stuff_q <= 1'b0;
        end else if (load) begin
            sh_q <= nb;
            bit_cnt_q <= 3'h0;
            crc_en_q <= ncrc;
            stuff_q <= nstuff;
        end else if (tick && streaming && !stuff_now) begin
            // R1 lsb leaves first
            sh_q <= sh_q >> 1;
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // serial output, mark when idle, held a full bit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_data_out <= 1'b1;
        end else if (tick) begin
            // R4 inserted zero
            tx_data_out <= streaming ? (!stuff_now && sh_q[0]) : 1'b1;
        end
    end

    // ones run counter, only inside stuffed bytes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ones_q <= 3'h0;
        end else if (!streaming) begin
            ones_q <= 3'h0;
        end else if (tick) begin
            ones_q <= (!stuff_now && stuff_q && sh_q[0]) ? ones_q + 3'h1 : 3'h0;
        end
    end

    // block check accumulator
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            crc_q <= CRC_PRESET;
        end else if (!streaming || (load && (state_q == ST_CRC_HI || st_d == ST_ABORT))) begin
            // R17 R21 restart at zero
            crc_q <= CRC_PRESET;
        end else if (tick && !stuff_now && crc_en_q) begin
            // R2 R3 fold the bit in
            crc_q <= sltx_crc_step(crc_q, sh_q[0], poly);
        end
    end

    // read return: data only in the cycle after a read
    // R7 host-initiated reads
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            read_return_bus <= 8'h00;
        end else if (!host_read_strobe) begin
            read_return_bus <= 8'h00;
        end else begin
            case (register_select)
                REG_TX_CTRL: read_return_bus <= {5'h00, abort_req_q, ctrl_q};
                REG_MODE: read_return_bus <= {3'h0, mode_q};
                // R18 modem lines visible
                REG_MODEM: read_return_bus <= {3'h0, ring_s, cts_s, dsr_s, rts_out, dtr_out};
                REG_SILO: read_return_bus <= {full, (7)'(cnt_q)};
                REG_STAT: read_return_bus <= {3'h0, eom_pend_q, msg_q, state_q};
                REG_CRC_LO: read_return_bus <= crc_q[7:0];
                REG_CRC_HI: read_return_bus <= crc_q[15:8];
                default: read_return_bus <= 8'h00;
            endcase
        end
    end

    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // eom character ends on the line
    sequence eom_byte_end;
        byte_done && eom_pend_q && !abort_req_q && (state_q == ST_RUN || state_q == ST_OPEN);
    endsequence

    // wait left for the first lead-in byte
    sequence wait_go;
        state_q == ST_WAIT ##1 state_q == ST_OPEN;
    endsequence

    lsb_first_a: assert property ( // R1
        (tick && streaming && !stuff_now) |=> tx_data_out == $past(sh_q[0]))
        else $error("bit sent is not the shifter lsb");
    zero_insert_a: assert property ( // R4
        (tick && streaming && stuff_now) |=> !tx_data_out && ones_q == 3'h0)
        else $error("no zero after five ones");
    rts_wake_a: assert property ( // R11
        (state_q == ST_IDLE && head_ok_q) |=> rts_out && state_q == ST_WAIT)
        else $error("rts not raised for silo data");
    modem_gate_a: assert property ( // R13
        wait_go |-> $past(ready))
        else $error("sending began without cts and dsr");
    som_excluded_a: assert property ( // R14
        (pop && head[ENT_SOM]) |=> !crc_en_q)
        else $error("som character entered crc");
    data_included_a: assert property ( // R15
        (pop && !head[ENT_SOM]) |=> crc_en_q && sh_q == $past(head[7:0]))
        else $error("data character left out of crc");
    bcc_follows_a: assert property ( // R16
        eom_byte_end |=> state_q == ST_CRC_LO && sh_q == $past(crc_out[7:0]))
        else $error("block check did not follow eom");
    crc_fresh_a: assert property ( // R17
        (load && state_q == ST_CRC_HI) |=> crc_q == CRC_PRESET)
        else $error("crc not restarted after check");
    full_drop_a: assert property ( // R22
        (host_write_strobe && register_select == REG_TX_DATA && full) |=> $stable(wp_q) && full)
        else $error("write to full silo was stored");
endmodule // sltx_top

// ---- sltx_modem_model.sv ----
// modem stand-in: answers the send request, makes the bit clock, records the line
module sltx_modem_model (
    input wire logic rts_out, // send request from the transmitter
    input wire logic tx_data_out, // serial line from the transmitter
    input wire logic hold_off, // bench order to leave the request unanswered
    output logic tx_clk_in, // bit clock, stands high outside frames
    output logic cts_in, // clear to send
    output logic dsr_in // data set ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic line_bits[$]; // captured line bits, oldest first
    // one pass of this loop per frame
    initial begin
        tx_clk_in = 1'h1;
        cts_in = 1'h0;
        dsr_in = 1'h0;
        forever begin
            wait (rts_out === 1'h1 && hold_off === 1'h0);
            #200;
            cts_in = 1'h1;
            dsr_in = 1'h1;
            // clock runs only while the frame is requested
            while (rts_out === 1'h1) begin
                #24;
                // the bit launched after the previous falling edge still stands at this sample
                line_bits.push_back(tx_data_out);
                tx_clk_in = 1'h0;
                #24;
                tx_clk_in = 1'h1;
            end
            // closing bit still stands half a bit time after the request is seen dropped
            #24;
            line_bits.push_back(tx_data_out);
            cts_in = 1'h0;
            dsr_in = 1'h0;
        end
    end
endmodule // sltx_modem_model

// ---- tb.sv ----
module tb import sltx_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys; // system clock
    logic resetn; // async reset, active low
    logic [3:0] register_select; // register index
    logic [7:0] host_write_bus; // write data
    logic host_write_strobe; // write pulse
    logic host_read_strobe; // read pulse
    logic [7:0] read_return_bus; // read data
    logic tx_clk_in, tx_data_out, rts_out, dtr_out, cts_in, dsr_in; // line and modem lines
    logic ring_in; // ring indication
    logic hold_off; // keeps the modem silent
    int n_fail; // mismatches seen
    int checks_done; // comparisons made
    int run_len; // run of ones in the expected stream
    logic exp_q[$]; // expected line bits

    sltx_top #(.DEPTH(SILO_DEPTH)) dut_u (.clk_sys(clk_sys), .resetn(resetn), .register_select(register_select),
        .host_write_bus(host_write_bus), .host_write_strobe(host_write_strobe), .host_read_strobe(host_read_strobe),
        .read_return_bus(read_return_bus), .tx_clk_in(tx_clk_in), .tx_data_out(tx_data_out), .rts_out(rts_out),
        .dtr_out(dtr_out), .cts_in(cts_in), .dsr_in(dsr_in), .ring_in(ring_in));
    sltx_modem_model mdm_u (.rts_out(rts_out), .tx_data_out(tx_data_out), .hold_off(hold_off),
        .tx_clk_in(tx_clk_in), .cts_in(cts_in), .dsr_in(dsr_in));

    // compare and count
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one write cycle, entered and left just after a rising edge
    task automatic wr(input logic [3:0] sel, input logic [7:0] val);
        register_select <= sel;
        host_write_bus <= val;
        host_write_strobe <= 1'h1;
        @(posedge clk_sys);
        host_write_strobe <= 1'h0;
        @(posedge clk_sys);
    endtask
    // one read cycle; data looked at in the following cycle only
    task automatic rd(input logic [3:0] sel, input logic [7:0] exp, input string what);
        register_select <= sel;
        host_read_strobe <= 1'h1;
        @(posedge clk_sys);
        host_read_strobe <= 1'h0;
        #1;
        chk(what, 16'(exp), 16'(read_return_bus));
        @(posedge clk_sys);
        #1;
        chk({what, " gone"}, 16'h0000, 16'(read_return_bus));
        @(posedge clk_sys);
    endtask
    // expected bits of one byte, lsb first, zero after five ones when stuffing
    task automatic put_byte(input logic [7:0] b, input bit stuff);
        for (int i = 0; i < 8; i++) begin
            exp_q.push_back(b[i]);
            run_len = b[i] ? run_len + 1 : 0;
            if (stuff && run_len == 5) begin
                exp_q.push_back(1'h0);
                run_len = 0;
            end
        end
    endtask
    // reflected block check over one byte
    function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b, input logic [15:0] poly);
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ b[i]) ? poly : 16'h0000);
        end
        return c;
    endfunction
    // two blocks in one frame: start char, data, end, then a second end char
    task automatic send_msg(input bit stuff, input bit inv);
        logic [7:0] chars [4] = '{8'h10, 8'hA5, 8'h3E, 8'h5C};
        logic [1:0] flags [4] = '{2'h1, 2'h0, 2'h2, 2'h2};
        logic [15:0] crc;
        logic [15:0] bc;
        logic [7:0] edge_char;
        int s;
        int w;
        edge_char = stuff ? FLAG_CHAR : PAD_CHAR;
        crc = CRC_PRESET;
        exp_q.delete();
        mdm_u.line_bits.delete();
        run_len = 0;
        wr(REG_MODE, {6'h01, inv, stuff});
        // byte mode aligns on the first data zero, stuff mode on the flag
        if (stuff) begin
            put_byte(edge_char, 1'h0);
        end
        run_len = 0;
        for (int k = 0; k < 4; k++) begin
            wr(REG_TX_CTRL, {6'h00, flags[k]});
            wr(REG_TX_DATA, chars[k]);
            put_byte(chars[k], stuff);
            if (!flags[k][CTRL_SOM]) begin
                crc = crc_add(crc, chars[k], stuff ? CCITT_POLY : CRC16_POLY);
            end
            if (flags[k][CTRL_EOM]) begin
                bc = inv ? ~crc : crc;
                put_byte(bc[7:0], stuff);
                put_byte(bc[15:8], stuff);
                crc = CRC_PRESET;
            end
        end
        put_byte(edge_char, 1'h0);
        rd(REG_SILO, 8'h04, "silo count");
        chk("rts raised", 16'h0001, 16'(rts_out));
        w = 0;
        while (rts_out !== 1'h0 && w < 4000) begin
            @(posedge clk_sys);
            w++;
        end
        chk("rts dropped", 16'h0000, 16'(rts_out));
        #100;
        @(posedge clk_sys);
        // first sample precedes any launch and shows the previous frame's last bit
        s = 1;
        while (s < mdm_u.line_bits.size() && mdm_u.line_bits[s] !== 1'h0) begin
            s++;
        end
        for (int i = 0; i < exp_q.size(); i++) begin
            chk($sformatf("line bit %0d", i), 16'(exp_q[i]), (s + i < mdm_u.line_bits.size()) ?
                16'(mdm_u.line_bits[s + i]) : 16'hFFFF);
        end
        $display("test frame stuff %0d invert %0d done", stuff, inv);
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // system clock
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #200000;
        n_fail++;
        $display("mismatch watchdog expected finish seen hang");
        summarize();
    end
    // main sequence
    initial begin
        resetn = 1'h0;
        register_select = 4'h0;
        host_write_bus = 8'h00;
        host_write_strobe = 1'h0;
        host_read_strobe = 1'h0;
        ring_in = 1'h0;
        hold_off = 1'h0;
        n_fail = 0;
        checks_done = 0;
        run_len = 0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'h1;
        @(posedge clk_sys);
        #1;
        chk("idle line", 16'h0001, 16'(tx_data_out));
        chk("rts dtr", 16'h0000, 16'({rts_out, dtr_out}));
        @(posedge clk_sys);
        rd(REG_MODE, 8'(MODE_RST), "mode reset");
        rd(REG_TX_CTRL, 8'(CTRL_RST), "ctrl reset");
        rd(4'hA, 8'h00, "unmapped");
        rd(REG_TX_DATA, 8'h00, "data reg");
        ring_in <= 1'h1;
        wr(REG_MODE, 8'h04);
        rd(REG_MODEM, 8'h11, "modem lines");
        chk("dtr", 16'h0001, 16'(dtr_out));
        $display("test registers done");
        send_msg(1'h0, 1'h0);
        send_msg(1'h1, 1'h0);
        send_msg(1'h0, 1'h1);
        // silent modem: silo fills and refuses, line stays idle
        hold_off <= 1'h1;
        wr(REG_MODE, 8'h04);
        wr(REG_TX_CTRL, 8'h00);
        for (int i = 0; i < 66; i++) begin
            wr(REG_TX_DATA, 8'(i));
        end
        rd(REG_SILO, 8'hC0, "silo full");
        chk("held line", 16'h0003, 16'({rts_out, tx_data_out}));
        wr(REG_TX_CTRL, 8'h04);
        rd(REG_TX_CTRL, 8'h04, "abort pending");
        wr(REG_MODE, 8'h1C);
        rd(REG_STAT, {5'h00, ST_OPEN}, "maint start");
        $display("test full silo done");
        summarize();
    end
endmodule // tb
